// ---- shared/uaw_pkg.sv ----
//
// Function
// - Set the overflow flag when the 16-bit baud counter wraps before edge five.
// - A baud counter overflow also sets the receive interrupt flag.
// - After overflow the baud counter keeps counting until the fifth rising edge.
// - Idle flag reads 0 during baud detection, set at the fifth rising edge.
// - A buffer read after overflow lets the fifth edge set the flag again.
// - Clearing detect enable early lets remaining falling edges start characters.
// - In sleep the baud generator stops and no character is received.
// - Wake on break works only in asynchronous mode.
// - Wake enable suspends reception and keeps the receiver idle.
// - A falling edge on the data line while wake is enabled wakes.
// - The wake event raises the receive interrupt flag.
// - Reading the receive buffer clears the wake interrupt condition.
// - The rising edge ending the break clears wake enable in hardware.
// - A non-zero character wakes at its first low time; rest is fragment.
//
package uaw_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RXBUF = 8'h08;
  localparam logic [7:0] OFS_DIVISOR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ABD_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_ASYNC_BIT = 2;
  localparam int ST_RIF_BIT = 0;
  localparam int ST_RIDL_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int IRQ_RXCHAR_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;
  localparam int IRQ_BAUD_BIT = 3;
  localparam int IRQ_W = 4;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam logic [15:0] DIVISOR_RESET = 16'h00D0;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
  localparam logic [2:0] ABD_LAST_RISE = 3'h3;
  localparam logic [2:0] ABD_PRESCALE_LAST = 3'h7;
  localparam logic [3:0] RX_DATA_BITS = 4'h8;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } uaw_rx_state_t;

  typedef enum logic [1:0] {
    AB_IDLE,
    AB_WAIT_FALL,
    AB_WAIT_RISE,
    AB_COUNT
  } uaw_abd_state_t;

endpackage : uaw_pkg

// ---- hw/uaw_baud_counter.sv ----
`timescale 1ns/1ps
module uaw_baud_counter #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic inc,
  output logic [WIDTH-1:0] cnt_reg,
  output logic ovf_reg
);

  // ----------------------------------------------------------------------
  // Free counter that wraps and keeps going after overflow.
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      ovf_reg <= 1'b0;
    end else if (clr) begin
      cnt_reg <= '0;
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= inc && (&cnt_reg);
      if (inc) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule : uaw_baud_counter

// ---- hw/uaw_top.sv ----
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module uaw_top #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic sleep,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Register bus.
  // ----------------------------------------------------------------------
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic wr_done;
  logic rd_done;
  logic hit;
  logic [2:0] ctrl_reg;
  logic ovf_flag_reg;
  logic rif_reg;
  logic ridl_reg;
  logic [7:0] rxbuf_reg;
  localparam int IRQ_W_L = uaw_pkg::IRQ_W;
  logic [15:0] div_reg;
  logic [IRQ_W_L-1:0] ist_reg;
  logic [IRQ_W_L-1:0] mask_reg;

  assign wr_done = psel && penable && pready_reg && pwrite;
  assign rd_done = psel && penable && pready_reg && !pwrite;
  assign hit = (paddr == uaw_pkg::OFS_CTRL) ||
               (paddr == uaw_pkg::OFS_STATUS) ||
               (paddr == uaw_pkg::OFS_RXBUF) ||
               (paddr == uaw_pkg::OFS_DIVISOR) ||
               (paddr == uaw_pkg::OFS_IRQ_STATUS) ||
               (paddr == uaw_pkg::OFS_IRQ_MASK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !hit;
      if (psel && !penable) begin
        case (paddr)
          uaw_pkg::OFS_CTRL: prdata_reg <= {29'h0, ctrl_reg};
          uaw_pkg::OFS_STATUS:
            prdata_reg <= {29'h0, ovf_flag_reg, ridl_reg, rif_reg};
          uaw_pkg::OFS_RXBUF: prdata_reg <= {24'h0, rxbuf_reg};
          uaw_pkg::OFS_DIVISOR: prdata_reg <= {16'h0, div_reg};
          uaw_pkg::OFS_IRQ_STATUS: prdata_reg <= {28'h0, ist_reg};
          uaw_pkg::OFS_IRQ_MASK: prdata_reg <= {28'h0, mask_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------------
  // Line edges and baud prescaler.
  // ----------------------------------------------------------------------
  logic rxd_prev_reg;
  logic rx_fall;
  logic rx_rise;
  logic [2:0] pre_reg;
  logic pre_tick;
  logic ab_ovf;
  logic [CNT_W-1:0] ab_cnt;
  uaw_pkg::uaw_abd_state_t ab_state_reg;
  logic [2:0] rise_cnt_reg;
  logic ab_done;
  logic ab_clr;

  assign rx_fall = rxd_prev_reg && !rxd;
  assign rx_rise = !rxd_prev_reg && rxd;
  assign pre_tick = (pre_reg == uaw_pkg::ABD_PRESCALE_LAST) && !sleep;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_prev_reg <= 1'b1;
      pre_reg <= 3'h0;
    end else begin
      rxd_prev_reg <= rxd;
      if (ab_clr) begin
        pre_reg <= 3'h0;
      end else if (!sleep) begin
        pre_reg <= pre_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Automatic baud detection.
  // ----------------------------------------------------------------------
  assign ab_clr = (ab_state_reg == uaw_pkg::AB_WAIT_RISE) && rx_rise;
  assign ab_done = (ab_state_reg == uaw_pkg::AB_COUNT) && rx_rise &&
                   (rise_cnt_reg == uaw_pkg::ABD_LAST_RISE);

  uaw_baud_counter #(.WIDTH(CNT_W)) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clr(ab_clr),
    .inc(pre_tick && (ab_state_reg == uaw_pkg::AB_COUNT)),
    .cnt_reg(ab_cnt),
    .ovf_reg(ab_ovf)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_state_reg <= uaw_pkg::AB_IDLE;
      rise_cnt_reg <= 3'h0;
    end else if (!ctrl_reg[uaw_pkg::CTRL_ABD_BIT]) begin
      ab_state_reg <= uaw_pkg::AB_IDLE;
      rise_cnt_reg <= 3'h0;
    end else begin
      case (ab_state_reg)
        uaw_pkg::AB_IDLE: ab_state_reg <= uaw_pkg::AB_WAIT_FALL;
        uaw_pkg::AB_WAIT_FALL: begin
          if (rx_fall) begin
            ab_state_reg <= uaw_pkg::AB_WAIT_RISE;
          end
        end
        uaw_pkg::AB_WAIT_RISE: begin
          if (rx_rise) begin
            ab_state_reg <= uaw_pkg::AB_COUNT;
            rise_cnt_reg <= 3'h0;
          end
        end
        uaw_pkg::AB_COUNT: begin
          if (ab_done) begin
            ab_state_reg <= uaw_pkg::AB_IDLE;
          end else if (rx_rise) begin
            rise_cnt_reg <= rise_cnt_reg + 3'h1;
          end
        end
        default: ab_state_reg <= uaw_pkg::AB_IDLE;
      endcase
    end
  end

  logic ovf_evt;
  assign ovf_evt = ab_ovf && (ab_state_reg == uaw_pkg::AB_COUNT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= uaw_pkg::DIVISOR_RESET;
    end else if (ab_done) begin
      div_reg <= (ab_cnt == '0) ? 16'h0001 : 16'(ab_cnt);
    end else if (wr_done && paddr == uaw_pkg::OFS_DIVISOR) begin
      div_reg <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Wake on break.
  // ----------------------------------------------------------------------
  logic wake_evt;
  logic wake_end;
  logic wake_seen_reg;
  logic wake_on;

  assign wake_on = ctrl_reg[uaw_pkg::CTRL_WAKE_BIT] &&
                   ctrl_reg[uaw_pkg::CTRL_ASYNC_BIT];
  assign wake_evt = wake_on && rx_fall && !wake_seen_reg;
  assign wake_end = wake_on && rx_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_seen_reg <= 1'b0;
    end else if (!wake_on || wake_end) begin
      wake_seen_reg <= 1'b0;
    end else if (wake_evt) begin
      wake_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= uaw_pkg::CTRL_RESET;
    end else if (wr_done && paddr == uaw_pkg::OFS_CTRL) begin
      ctrl_reg <= pwdata[2:0];
    end else begin
      if (ab_done) begin
        ctrl_reg[uaw_pkg::CTRL_ABD_BIT] <= 1'b0;
      end
      if (wake_end) begin
        ctrl_reg[uaw_pkg::CTRL_WAKE_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Character receiver.
  // ----------------------------------------------------------------------
  uaw_pkg::uaw_rx_state_t rx_state_reg;
  logic [15:0] tick_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic rx_hold;
  logic rx_char;

  assign rx_hold = sleep || ctrl_reg[uaw_pkg::CTRL_ABD_BIT] ||
                   wake_on;
  assign rx_char = (rx_state_reg == uaw_pkg::RX_STOP) &&
                   (tick_reg == div_reg - 16'h0001) && !rx_hold;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= uaw_pkg::RX_IDLE;
      tick_reg <= 16'h0000;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (rx_hold) begin
      rx_state_reg <= uaw_pkg::RX_IDLE;
      tick_reg <= 16'h0000;
    end else begin
      case (rx_state_reg)
        uaw_pkg::RX_IDLE: begin
          tick_reg <= 16'h0000;
          if (rx_fall) begin
            rx_state_reg <= uaw_pkg::RX_START;
          end
        end
        uaw_pkg::RX_START: begin
          tick_reg <= tick_reg + 16'h0001;
          if (tick_reg == {1'b0, div_reg[15:1]}) begin
            tick_reg <= 16'h0000;
            bit_cnt_reg <= 4'h0;
            rx_state_reg <= rxd ? uaw_pkg::RX_IDLE : uaw_pkg::RX_DATA;
          end
        end
        uaw_pkg::RX_DATA: begin
          tick_reg <= tick_reg + 16'h0001;
          if (tick_reg == div_reg - 16'h0001) begin
            tick_reg <= 16'h0000;
            shift_reg <= {rxd, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == uaw_pkg::RX_DATA_BITS - 4'h1) begin
              rx_state_reg <= uaw_pkg::RX_STOP;
            end
          end
        end
        uaw_pkg::RX_STOP: begin
          tick_reg <= tick_reg + 16'h0001;
          if (rx_char) begin
            rx_state_reg <= uaw_pkg::RX_IDLE;
          end
        end
        default: rx_state_reg <= uaw_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_reg <= 8'h00;
    end else if (rx_char) begin
      rxbuf_reg <= shift_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Flags and interrupt.
  // ----------------------------------------------------------------------
  logic buf_read;
  logic rif_set;
  logic [IRQ_W_L-1:0] ist_set;

  assign buf_read = rd_done && paddr == uaw_pkg::OFS_RXBUF;
  assign rif_set = rx_char || ovf_evt || ab_done || wake_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif_reg <= 1'b0;
    end else if (rif_set) begin
      rif_reg <= 1'b1;
    end else if (buf_read) begin
      rif_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_reg <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_reg <= 1'b1;
    end else if (wr_done && paddr == uaw_pkg::OFS_STATUS &&
                 pwdata[uaw_pkg::ST_OVF_BIT]) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ridl_reg <= 1'b1;
    end else begin
      ridl_reg <= !ctrl_reg[uaw_pkg::CTRL_ABD_BIT] &&
                  (rx_state_reg == uaw_pkg::RX_IDLE);
    end
  end

  assign ist_set = {ab_done, ovf_evt, wake_evt, rx_char};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= '0;
    end else if (rd_done && paddr == uaw_pkg::OFS_IRQ_STATUS) begin
      ist_reg <= ist_set;
    end else begin
      ist_reg <= ist_reg | ist_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= uaw_pkg::MASK_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_done && paddr == uaw_pkg::OFS_IRQ_MASK) begin
        mask_reg <= pwdata[IRQ_W_L-1:0];
      end
      irq <= |(ist_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_count_wrap;
    ovf_evt;
  endsequence

  sequence s_flags_up;
    rif_reg && ovf_flag_reg;
  endsequence

  a_ovf_sets_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_count_wrap |=> s_flags_up)
    else $error("overflow did not set both flags");

  a_ovf_keeps_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    ovf_evt && !rx_rise && ctrl_reg[uaw_pkg::CTRL_ABD_BIT]
    |=> ab_state_reg == uaw_pkg::AB_COUNT)
    else $error("baud detection stopped at overflow");

  a_idle_low_abd: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_reg[uaw_pkg::CTRL_ABD_BIT] |=> !ridl_reg)
    else $error("idle flag high during baud detection");

  a_fifth_edge_rif: assert property (
    @(posedge pclk) disable iff (!presetn)
    ab_done |=> rif_reg && !ctrl_reg[uaw_pkg::CTRL_ABD_BIT] ##1 ridl_reg)
    else $error("fifth edge did not finish detection");

  a_sleep_halts: assert property (
    @(posedge pclk) disable iff (!presetn)
    sleep |=> rx_state_reg == uaw_pkg::RX_IDLE && pre_reg == $past(pre_reg))
    else $error("receiver ran in sleep");

  a_wake_holds_rx: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake_on |=> rx_state_reg == uaw_pkg::RX_IDLE)
    else $error("receiver active with wake enabled");

  a_wake_sets_rif: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake_evt |=> rif_reg)
    else $error("wake event did not set flag");

  a_read_clears_rif: assert property (
    @(posedge pclk) disable iff (!presetn)
    buf_read && !rif_set |=> !rif_reg)
    else $error("buffer read did not clear flag");

  a_break_end_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake_end && !wr_done |=> !ctrl_reg[uaw_pkg::CTRL_WAKE_BIT])
    else $error("wake enable not cleared at break end");

  a_wake_async_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg[uaw_pkg::CTRL_ASYNC_BIT] && rx_fall |=> !wake_seen_reg)
    else $error("wake detected outside asynchronous mode");

endmodule : uaw_top

// ---- dv/uaw_node.sv ----
`timescale 1ns/1ps
module uaw_node (
  input wire logic pclk,
  output logic rxd
);
  // ----------------------------------------------------------------------
  // Remote serial node driving the receive data line.
  // ----------------------------------------------------------------------
  initial rxd = 1'b1;

  // Holds the line at one level for n clock cycles.
  task automatic hold(input logic lvl, input int n);
    @(posedge pclk);
    rxd <= lvl;
    repeat (n - 1) @(posedge pclk);
  endtask : hold

  // Sends one 8N1 character, least significant bit first.
  task automatic send_byte(input logic [7:0] b, input int bitc);
    hold(1'b0, bitc);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], bitc);
    end
    hold(1'b1, bitc);
  endtask : send_byte

  // Holds the line low for nbits bit times, then high for four bit times.
  task automatic send_break(input int bitc, input int nbits);
    hold(1'b0, bitc * nbits);
    hold(1'b1, bitc * 4);
  endtask : send_break
endmodule : uaw_node

// ---- dv/uaw_top_bench.sv ----
`timescale 1ns/1ps
module uaw_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rxd, sleep, irq, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rr;
  int error_cnt, n_checks, cycles;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } uaw_row_t;
  uaw_row_t rows[13];

  uaw_top #(.CNT_W(8)) uaw_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .sleep(sleep), .irq(irq));
  uaw_node uaw_node_inst (.pclk(pclk), .rxd(rxd));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] x,
                          input string m);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic x, input string m);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %b want %b", $time, m, g, x);
    end
  endtask : chk_bit

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rr = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk_bit(re, 1'b0, "write error");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk_word(rr, x, "read data");
  endtask : rd

  task automatic rd_bit(input logic [7:0] a, input int i, input logic x);
    apb(1'b0, a, 32'h0);
    chk_bit(rr[i], x, "read bit");
  endtask : rd_bit

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    rows = '{
      '{1'b0, uaw_pkg::OFS_CTRL, 32'h0, 32'h4, 1'b0},
      '{1'b0, uaw_pkg::OFS_STATUS, 32'h0, 32'h2, 1'b0},
      '{1'b0, uaw_pkg::OFS_RXBUF, 32'h0, 32'h0, 1'b0},
      '{1'b0, uaw_pkg::OFS_DIVISOR, 32'h0, 32'hD0, 1'b0},
      '{1'b0, uaw_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0, 1'b0},
      '{1'b0, uaw_pkg::OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h18, 32'hFFFF, 32'h0, 1'b1},
      '{1'b1, uaw_pkg::OFS_DIVISOR, 32'h0, 32'h0, 1'b0},
      '{1'b0, uaw_pkg::OFS_DIVISOR, 32'h0, 32'h1, 1'b0},
      '{1'b1, uaw_pkg::OFS_DIVISOR, 32'h10, 32'h0, 1'b0},
      '{1'b0, uaw_pkg::OFS_DIVISOR, 32'h0, 32'h10, 1'b0},
      '{1'b0, uaw_pkg::OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // ----------------------------------------------------------------------
    // Register table.
    // ----------------------------------------------------------------------
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) begin
        chk_word(rr, rows[i].x, "table read");
      end
      chk_bit(re, rows[i].e, "table error");
    end
    // ----------------------------------------------------------------------
    // Reception, masking and interrupt clear.
    // ----------------------------------------------------------------------
    uaw_node_inst.send_byte(8'hA5, 16);
    repeat (4) @(posedge pclk);
    rd(uaw_pkg::OFS_STATUS, 32'h3);
    chk_bit(irq, 1'b0, "masked irq");
    wr(uaw_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b1, "unmasked irq");
    rd(uaw_pkg::OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0, "irq after clear");
    rd(uaw_pkg::OFS_RXBUF, 32'hA5);
    rd(uaw_pkg::OFS_STATUS, 32'h2);
    // ----------------------------------------------------------------------
    // Baud detection, then early cancel.
    // ----------------------------------------------------------------------
    wr(uaw_pkg::OFS_CTRL, 32'h5);
    rd_bit(uaw_pkg::OFS_STATUS, uaw_pkg::ST_RIDL_BIT, 1'b0);
    uaw_node_inst.send_byte(8'h55, 24);
    repeat (4) @(posedge pclk);
    rd(uaw_pkg::OFS_DIVISOR, 32'd23);
    rd(uaw_pkg::OFS_CTRL, 32'h4);
    rd(uaw_pkg::OFS_STATUS, 32'h3);
    rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_BAUD_BIT, 1'b1);
    apb(1'b0, uaw_pkg::OFS_RXBUF, 32'h0);
    wr(uaw_pkg::OFS_CTRL, 32'h5);
    wr(uaw_pkg::OFS_CTRL, 32'h4);
    uaw_node_inst.send_byte(8'h3C, 24);
    repeat (4) @(posedge pclk);
    rd(uaw_pkg::OFS_RXBUF, 32'h3C);
    // ----------------------------------------------------------------------
    // Baud counter overflow with a slow sync character.
    // ----------------------------------------------------------------------
    wr(uaw_pkg::OFS_CTRL, 32'h5);
    fork
      uaw_node_inst.send_byte(8'h55, 264);
      begin
        repeat (2330) @(posedge pclk);
        rd(uaw_pkg::OFS_STATUS, 32'h5);
        apb(1'b0, uaw_pkg::OFS_RXBUF, 32'h0);
        rd(uaw_pkg::OFS_STATUS, 32'h4);
      end
    join
    rd(uaw_pkg::OFS_STATUS, 32'h7);
    rd(uaw_pkg::OFS_DIVISOR, 32'h7);
    rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_OVF_BIT, 1'b1);
    apb(1'b0, uaw_pkg::OFS_RXBUF, 32'h0);
    wr(uaw_pkg::OFS_STATUS, 32'h4);
    rd(uaw_pkg::OFS_STATUS, 32'h2);
    wr(uaw_pkg::OFS_DIVISOR, 32'd23);
    // ----------------------------------------------------------------------
    // Wake on break.
    // ----------------------------------------------------------------------
    apb(1'b0, uaw_pkg::OFS_IRQ_STATUS, 32'h0);
    wr(uaw_pkg::OFS_IRQ_MASK, 32'h2);
    rd_bit(uaw_pkg::OFS_STATUS, uaw_pkg::ST_RIDL_BIT, 1'b1);
    wr(uaw_pkg::OFS_CTRL, 32'h6);
    fork
      uaw_node_inst.hold(1'b0, 24 * 13);
      begin
        repeat (30) @(posedge pclk);
        rd(uaw_pkg::OFS_STATUS, 32'h3);
        chk_bit(irq, 1'b1, "wake irq");
        rd(uaw_pkg::OFS_CTRL, 32'h6);
        rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_WAKE_BIT, 1'b1);
      end
    join
    uaw_node_inst.hold(1'b1, 96);
    rd(uaw_pkg::OFS_CTRL, 32'h4);
    rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_RXCHAR_BIT, 1'b0);
    apb(1'b0, uaw_pkg::OFS_RXBUF, 32'h0);
    rd(uaw_pkg::OFS_STATUS, 32'h2);
    wr(uaw_pkg::OFS_CTRL, 32'h6);
    uaw_node_inst.send_byte(8'h01, 24);
    rd(uaw_pkg::OFS_CTRL, 32'h4);
    rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_WAKE_BIT, 1'b1);
    repeat (60) @(posedge pclk);
    apb(1'b0, uaw_pkg::OFS_RXBUF, 32'h0);
    wr(uaw_pkg::OFS_CTRL, 32'h2);
    uaw_node_inst.send_break(24, 4);
    rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_WAKE_BIT, 1'b0);
    wr(uaw_pkg::OFS_CTRL, 32'h4);
    apb(1'b0, uaw_pkg::OFS_RXBUF, 32'h0);
    // ----------------------------------------------------------------------
    // Sleep and a reset in mid-run.
    // ----------------------------------------------------------------------
    @(posedge pclk);
    sleep <= 1'b1;
    uaw_node_inst.send_byte(8'h5A, 24);
    repeat (4) @(posedge pclk);
    rd_bit(uaw_pkg::OFS_IRQ_STATUS, uaw_pkg::IRQ_RXCHAR_BIT, 1'b0);
    sleep <= 1'b0;
    wr(uaw_pkg::OFS_CTRL, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(uaw_pkg::OFS_CTRL, 32'h4);
    rd(uaw_pkg::OFS_DIVISOR, 32'hD0);
    give_verdict();
  end
endmodule : uaw_top_bench
